/* src/rcr_pkg.sv */
/*
 Reset cause recorder package: flag positions, reset patterns, vectors,
 event indices and state codes. Assumes a 15-bit program counter.
*/
package rcr_pkg;
	localparam int PC_W = 15;
	localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC   = 15'h0004;
	localparam logic [PC_W-1:0] PC_STEP   = 15'h0001;

	// Power-control bit positions; bit 5 is unimplemented
	localparam int CAUSE_STACK_OVER  = 7;
	localparam int CAUSE_STACK_UNDER = 6;
	localparam int CAUSE_WATCHDOG    = 4;
	localparam int CAUSE_PIN         = 3;
	localparam int CAUSE_INSTR       = 2;
	localparam int CAUSE_POWER_ON    = 1;
	localparam int CAUSE_BROWNOUT    = 0;
	localparam logic [7:0] CAUSE_MASK        = 8'hDF;
	// Brown-out flag is undefined at power-on; it takes bit 0 of this
	localparam logic [7:0] CAUSE_POR_RST     = 8'h1C;
	localparam logic       TIMEOUT_POR_RST   = 1'h1;
	localparam logic       POWERDOWN_POR_RST = 1'h1;

	// Event indices, highest priority first
	localparam int EV_BROWNOUT    = 0;
	localparam int EV_PIN         = 1;
	localparam int EV_WATCHDOG    = 2;
	localparam int EV_STACK_OVER  = 3;
	localparam int EV_STACK_UNDER = 4;
	localparam int EV_RESET       = 5;
	localparam int EV_IRQ         = 6;
	localparam int EV_N           = 7;

	typedef enum logic [2:0]
	{
		RCR_RUN   = 3'h1,
		RCR_SLEEP = 3'h2,
		RCR_VEC   = 3'h4
	} rcr_state_t;
endpackage

/* src/rcr_evt_if.sv */
/*
 Event carrier between the arbiter, the restart selector and the recorder.
 Assumes all three sit on clock_in.
*/
`timescale 1ns/1ps
interface rcr_evt_if;
	import rcr_pkg::*;
	logic [EV_N-1:0] grant;
	logic            asleep;
	logic [PC_W-1:0] pc_cur;
	logic            fire;
	logic [PC_W-1:0] addr;
	logic [PC_W-1:0] resume;

	modport arb (output grant, input asleep);
	modport sel (input grant, input asleep, input pc_cur, output fire, output addr, output resume);
	modport rec (input grant, output asleep, output pc_cur, input fire, input addr, input resume);
endinterface

/* src/rcr_arbiter.sv */
/*
 Priority arbiter: turns the raw reset and wake sources into one granted
 event per cycle. Assumes inputs are synchronous to clock_in.
*/
`timescale 1ns/1ps
module rcr_arbiter
	import rcr_pkg::*;
(
	input  wire logic brownout_in,
	input  wire logic master_clear_pin_b_in,
	input  wire logic watchdog_timeout_in,
	input  wire logic stack_overflow_in,
	input  wire logic stack_underflow_in,
	input  wire logic stack_reset_enable_in,
	input  wire logic reset_instr_in,
	input  wire logic irq_wake_in,
	rcr_evt_if.arb    evt
);
	logic [EV_N-1:0] req;

	always_comb
	begin
		req = '0;
		req[EV_BROWNOUT]    = brownout_in;
		req[EV_PIN]         = ~master_clear_pin_b_in;
		req[EV_WATCHDOG]    = watchdog_timeout_in;
		req[EV_STACK_OVER]  = stack_overflow_in & stack_reset_enable_in;
		req[EV_STACK_UNDER] = stack_underflow_in & stack_reset_enable_in;
		req[EV_RESET]       = reset_instr_in;
		// Interrupts only matter as a wake source here
		req[EV_IRQ]         = irq_wake_in & evt.asleep;
	end

	assign evt.grant[0] = req[0];
	genvar i;
	generate
		for (i = 1; i < EV_N; i++)
		begin : g_pri
			assign evt.grant[i] = req[i] & ~|req[i-1:0];
		end
	endgenerate
endmodule

/* src/rcr_restart_sel.sv */
/*
 Restart address selector: reset vector for resets, next instruction for
 wake-ups. Assumes the program counter wraps at its width.
*/
`timescale 1ns/1ps
module rcr_restart_sel
	import rcr_pkg::*;
(
	rcr_evt_if.sel evt
);
	logic wake;

	always_comb
	begin
		wake       = evt.grant[EV_IRQ] | (evt.grant[EV_WATCHDOG] & evt.asleep);
		evt.fire   = |evt.grant;
		evt.resume = evt.pc_cur + PC_STEP;
		evt.addr   = wake ? evt.resume : RESET_VEC;
	end
endmodule

/* src/reset_cause_recorder.sv */
/*
 Reset cause recorder: keeps the timeout and powerdown status flags and the
 power-control cause flags, and issues the restart address to the core.
 Assumes all sources are one-cycle pulses or levels on clock_in and that
 rst_b_in is the power-on reset.
*/
`timescale 1ns/1ps
module reset_cause_recorder
	import rcr_pkg::*;
(
	input  wire logic            clock_in,
	input  wire logic            rst_b_in,
	input  wire logic            brownout_in,
	input  wire logic            master_clear_pin_b_in,
	input  wire logic            watchdog_timeout_in,
	input  wire logic            stack_overflow_in,
	input  wire logic            stack_underflow_in,
	input  wire logic            stack_reset_enable_in,
	input  wire logic            reset_instr_in,
	input  wire logic            sleep_instr_in,
	input  wire logic            irq_wake_in,
	input  wire logic            global_irq_enable_in,
	input  wire logic [PC_W-1:0] pc_in,
	input  wire logic            cause_write_in,
	input  wire logic [7:0]      cause_wdata_in,
	output logic                 timeout_flag_out,
	output logic                 powerdown_flag_out,
	output logic [7:0]           cause_flags_out,
	output logic                 asleep_out,
	output logic                 restart_out,
	output logic [PC_W-1:0]      restart_addr_out,
	output logic                 stack_push_out,
	output logic [PC_W-1:0]      push_addr_out
);
	rcr_evt_if evt ();

	rcr_state_t      state_reg;
	rcr_state_t      state_next;
	logic            timeout_reg;
	logic            timeout_next;
	logic            powerdown_reg;
	logic            powerdown_next;
	logic [7:0]      cause_reg;
	logic [7:0]      cause_next;
	logic            restart_reg;
	logic            restart_next;
	logic [PC_W-1:0] addr_reg;
	logic [PC_W-1:0] addr_next;
	logic            push_reg;
	logic            push_next;
	logic [PC_W-1:0] push_addr_reg;
	logic [PC_W-1:0] push_addr_next;
	logic            asleep;

	assign asleep     = (state_reg == RCR_SLEEP);
	assign evt.asleep = asleep;
	assign evt.pc_cur = pc_in;

	rcr_arbiter u_arb
	(
		.brownout_in           (brownout_in),
		.master_clear_pin_b_in (master_clear_pin_b_in),
		.watchdog_timeout_in   (watchdog_timeout_in),
		.stack_overflow_in     (stack_overflow_in),
		.stack_underflow_in    (stack_underflow_in),
		.stack_reset_enable_in (stack_reset_enable_in),
		.reset_instr_in        (reset_instr_in),
		.irq_wake_in           (irq_wake_in),
		.evt                   (evt)
	);

	rcr_restart_sel u_sel
	(
		.evt (evt)
	);

	// Cause flags: software write first, a same-cycle event overrides it
	always_comb
	begin
		timeout_next   = timeout_reg;
		powerdown_next = powerdown_reg;
		cause_next     = cause_reg;
		if (cause_write_in)
		begin
			cause_next = cause_wdata_in & CAUSE_MASK;
		end
		if (evt.grant[EV_BROWNOUT])
		begin
			cause_next[CAUSE_STACK_OVER]  = 1'b0;
			cause_next[CAUSE_STACK_UNDER] = 1'b0;
			cause_next[CAUSE_BROWNOUT]    = 1'b0;
			cause_next[CAUSE_PIN]         = 1'b1;
			cause_next[CAUSE_INSTR]       = 1'b1;
			timeout_next                  = 1'b1;
			powerdown_next                = 1'b1;
		end
		if (evt.grant[EV_PIN])
		begin
			cause_next[CAUSE_PIN] = 1'b0;
			if (asleep)
			begin
				timeout_next   = 1'b1;
				powerdown_next = 1'b0;
			end
		end
		if (evt.grant[EV_WATCHDOG])
		begin
			timeout_next = 1'b0;
			if (asleep)
			begin
				powerdown_next = 1'b0;
			end
			else
			begin
				cause_next[CAUSE_WATCHDOG] = 1'b0;
			end
		end
		if (evt.grant[EV_STACK_OVER])
		begin
			cause_next[CAUSE_STACK_OVER] = 1'b1;
		end
		if (evt.grant[EV_STACK_UNDER])
		begin
			cause_next[CAUSE_STACK_UNDER] = 1'b1;
		end
		if (evt.grant[EV_RESET])
		begin
			cause_next[CAUSE_INSTR] = 1'b0;
		end
		if (evt.grant[EV_IRQ])
		begin
			timeout_next   = 1'b1;
			powerdown_next = 1'b0;
		end
	end

	// Restart sequencing
	always_comb
	begin
		state_next     = state_reg;
		restart_next   = 1'b0;
		addr_next      = addr_reg;
		push_next      = 1'b0;
		push_addr_next = push_addr_reg;
		unique case (state_reg)
			RCR_RUN:
			begin
				if (evt.fire)
				begin
					restart_next = 1'b1;
					addr_next    = evt.addr;
				end
				else if (sleep_instr_in)
				begin
					state_next = RCR_SLEEP;
				end
			end
			RCR_SLEEP:
			begin
				if (evt.fire)
				begin
					restart_next = 1'b1;
					addr_next    = evt.addr;
					state_next   = RCR_RUN;
					// Vector only after the resumed instruction slot
					if (evt.grant[EV_IRQ] && global_irq_enable_in)
					begin
						state_next     = RCR_VEC;
						push_addr_next = evt.resume;
					end
				end
			end
			RCR_VEC:
			begin
				state_next   = RCR_RUN;
				restart_next = 1'b1;
				addr_next    = IRQ_VEC;
				push_next    = 1'b1;
				// A reset arriving here outranks the vector
				if (evt.fire && !evt.grant[EV_IRQ])
				begin
					addr_next = evt.addr;
					push_next = 1'b0;
				end
			end
			default:
			begin
				state_next = RCR_RUN;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_reg     <= RCR_RUN;
			timeout_reg   <= TIMEOUT_POR_RST;
			powerdown_reg <= POWERDOWN_POR_RST;
			cause_reg     <= CAUSE_POR_RST;
			restart_reg   <= 1'b0;
			addr_reg      <= RESET_VEC;
			push_reg      <= 1'b0;
			push_addr_reg <= RESET_VEC;
		end
		else
		begin
			state_reg     <= state_next;
			timeout_reg   <= timeout_next;
			powerdown_reg <= powerdown_next;
			cause_reg     <= cause_next;
			restart_reg   <= restart_next;
			addr_reg      <= addr_next;
			push_reg      <= push_next;
			push_addr_reg <= push_addr_next;
		end
	end

	assign timeout_flag_out   = timeout_reg;
	assign powerdown_flag_out = powerdown_reg;
	assign cause_flags_out    = cause_reg;
	assign asleep_out         = asleep;
	assign restart_out        = restart_reg;
	assign restart_addr_out   = addr_reg;
	assign stack_push_out     = push_reg;
	assign push_addr_out      = push_addr_reg;

	// Checking helpers
	logic       first_reg;
	logic [7:0] cause_base;

	// Flags as an event finds them, a same-cycle software write included
	assign cause_base = cause_write_in ? (cause_wdata_in & CAUSE_MASK) : cause_reg;

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			first_reg <= 1'b1;
		end
		else
		begin
			first_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	chk_por_pattern: assert property (
		first_reg |-> timeout_reg && powerdown_reg && cause_reg == CAUSE_POR_RST && addr_reg == RESET_VEC)
		else $error("power-on flag pattern wrong");

	chk_bor_flags: assert property (
		evt.grant[EV_BROWNOUT] |=> !cause_reg[CAUSE_BROWNOUT] && !cause_reg[CAUSE_STACK_OVER]
			&& !cause_reg[CAUSE_STACK_UNDER] && cause_reg[CAUSE_PIN] && cause_reg[CAUSE_INSTR]
			&& timeout_reg && powerdown_reg
			&& cause_reg[CAUSE_WATCHDOG] == $past(cause_base[CAUSE_WATCHDOG])
			&& cause_reg[CAUSE_POWER_ON] == $past(cause_base[CAUSE_POWER_ON])
			&& restart_out && addr_reg == RESET_VEC)
		else $error("brown-out flags wrong");

	chk_wdt_running: assert property (
		evt.grant[EV_WATCHDOG] && !asleep |=> !cause_reg[CAUSE_WATCHDOG] && !timeout_reg
			&& powerdown_reg == $past(powerdown_reg) && restart_out && addr_reg == RESET_VEC)
		else $error("watchdog reset handling wrong");

	chk_wdt_wake: assert property (
		evt.grant[EV_WATCHDOG] && asleep |=> !timeout_reg && !powerdown_reg && cause_reg == $past(cause_base)
			&& restart_out && addr_reg == $past(pc_in) + PC_STEP && state_reg == RCR_RUN)
		else $error("watchdog wake handling wrong");

	// A reset in the vector cycle replaces the vector
	chk_irq_vector: assert property (
		evt.grant[EV_IRQ] && global_irq_enable_in && !cause_write_in
		|=> timeout_reg && !powerdown_reg && addr_reg == push_addr_reg
		##1 stack_push_out == !$past(evt.fire) && addr_reg == ($past(evt.fire) ? RESET_VEC : IRQ_VEC)
			&& push_addr_reg == $past(pc_in, 2) + PC_STEP)
		else $error("interrupt wake vector wrong");

	chk_irq_no_vector: assert property (
		evt.grant[EV_IRQ] && !global_irq_enable_in |=> restart_out && state_reg == RCR_RUN ##1 !stack_push_out)
		else $error("interrupt wake vectored without enable");

	chk_master_clear_pin_pin: assert property (
		evt.grant[EV_PIN] |=> !cause_reg[CAUSE_PIN] && addr_reg == RESET_VEC
			&& timeout_reg == ($past(asleep) | $past(timeout_reg))
			&& powerdown_reg == ($past(powerdown_reg) & !$past(asleep)))
		else $error("pin reset handling wrong");

	chk_reset_instr: assert property (
		evt.grant[EV_RESET] |=> !cause_reg[CAUSE_INSTR] && $stable(timeout_reg) && addr_reg == RESET_VEC)
		else $error("reset instruction handling wrong");

	// The vector cycle restarts on its own, so it is left out here
	chk_stack_flags: assert property (
		(stack_overflow_in || stack_underflow_in) && !stack_reset_enable_in && !cause_write_in
			&& !brownout_in && master_clear_pin_b_in && !watchdog_timeout_in && !reset_instr_in
			&& !(irq_wake_in && asleep) && state_reg != RCR_VEC |=> $stable(cause_reg) && !restart_out)
		else $error("disabled stack event acted");

	chk_stack_over_flag_set: assert property (
		evt.grant[EV_STACK_OVER] |=> cause_reg[CAUSE_STACK_OVER] && restart_out && addr_reg == RESET_VEC)
		else $error("stack overflow flag not set");

	chk_stack_under_flag_set: assert property (
		evt.grant[EV_STACK_UNDER] |=> cause_reg[CAUSE_STACK_UNDER] && restart_out && addr_reg == RESET_VEC)
		else $error("stack underflow flag not set");

	chk_sleep_entry: assert property (
		state_reg == RCR_RUN && sleep_instr_in && !evt.fire
		|=> asleep && !restart_out && $stable(timeout_reg) && $stable(powerdown_reg))
		else $error("sleep entry changed status flags");

	chk_sw_write: assert property (
		cause_write_in && !evt.fire |=> cause_reg == ($past(cause_wdata_in) & CAUSE_MASK))
		else $error("software flag write lost");
endmodule

/* verif/reset_cause_recorder_tb.sv */
/*
 Self-checking bench for the reset cause recorder: drives every reset and wake
 source by hand and judges flags, restart address and push outputs.
 Assumes the src/ package, interface and modules are compiled first.
*/
`timescale 1ns/1ps
module reset_cause_recorder_tb import rcr_pkg::*;;
	logic            clock_in = 1'b0;
	logic            rst_b_in = 1'b0;
	logic [7:0]      ev_mask = 8'h00;
	logic            stack_reset_enable_in = 1'b0;
	logic            global_irq_enable_in = 1'b0;
	logic [PC_W-1:0] pc_in = 15'h0ABC;
	logic            cause_write_in = 1'b0;
	logic [7:0]      cause_wdata_in = 8'h00;
	logic            timeout_flag_out;
	logic            powerdown_flag_out;
	logic [7:0]      cause_flags_out;
	logic            asleep_out;
	logic            restart_out;
	logic [PC_W-1:0] restart_addr_out;
	logic            stack_push_out;
	logic [PC_W-1:0] push_addr_out;
	int              n_mismatch = 0;
	int              checked = 0;
	int              cycles = 0;

	always #50 clock_in = ~clock_in;

	// Mask bits: 0 brown-out, 1 pin, 2 watchdog, 3 overflow, 4 underflow, 5 reset instr, 6 irq, 7 sleep
	reset_cause_recorder dut (
		.clock_in              (clock_in),
		.rst_b_in              (rst_b_in),
		.brownout_in           (ev_mask[0]),
		.master_clear_pin_b_in (~ev_mask[1]),
		.watchdog_timeout_in   (ev_mask[2]),
		.stack_overflow_in     (ev_mask[3]),
		.stack_underflow_in    (ev_mask[4]),
		.stack_reset_enable_in (stack_reset_enable_in),
		.reset_instr_in        (ev_mask[5]),
		.sleep_instr_in        (ev_mask[7]),
		.irq_wake_in           (ev_mask[6]),
		.global_irq_enable_in  (global_irq_enable_in),
		.pc_in                 (pc_in),
		.cause_write_in        (cause_write_in),
		.cause_wdata_in        (cause_wdata_in),
		.timeout_flag_out      (timeout_flag_out),
		.powerdown_flag_out    (powerdown_flag_out),
		.cause_flags_out       (cause_flags_out),
		.asleep_out            (asleep_out),
		.restart_out           (restart_out),
		.restart_addr_out      (restart_addr_out),
		.stack_push_out        (stack_push_out),
		.push_addr_out         (push_addr_out)
	);

	task automatic tally_and_finish;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cmp_word(input string what, input logic [14:0] exp, input logic [14:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Sources held for one cycle; outputs are judged at the following falling edge
	task automatic ev(input logic [7:0] m);
		@(negedge clock_in);
		ev_mask = m;
		@(negedge clock_in);
		ev_mask = 8'h00;
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge clock_in);
		cause_write_in = 1'b1;
		cause_wdata_in = d;
		@(negedge clock_in);
		cause_write_in = 1'b0;
	endtask

	task automatic chk(input logic t, input logic p, input logic [7:0] pc, input logic r, input logic [14:0] a);
		cmp_bit("timeout_flag", t, timeout_flag_out);
		cmp_bit("powerdown_flag", p, powerdown_flag_out);
		cmp_word("cause_flags", {7'h00, pc}, {7'h00, cause_flags_out});
		cmp_bit("restart", r, restart_out);
		if (r)
			cmp_word("restart_addr", a, restart_addr_out);
	endtask

	task automatic t_por;
		chk(1'b1, 1'b1, 8'h1C, 1'b0, 15'h0000);
		cmp_bit("asleep", 1'b0, asleep_out);
	endtask

	task automatic t_write;
		wr(8'hFF);
		chk(1'b1, 1'b1, 8'hDF, 1'b0, 15'h0000);
		wr(8'h20);
		chk(1'b1, 1'b1, 8'h00, 1'b0, 15'h0000);
	endtask

	task automatic t_run_resets;
		wr(8'hFF);
		ev(8'h04);
		chk(1'b0, 1'b1, 8'hCF, 1'b1, 15'h0000);
		ev(8'h02);
		chk(1'b0, 1'b1, 8'hC7, 1'b1, 15'h0000);
		ev(8'h20);
		chk(1'b0, 1'b1, 8'hC3, 1'b1, 15'h0000);
	endtask

	// Watchdog in the same cycle must lose to brown-out
	task automatic t_brownout;
		wr(8'h52);
		ev(8'h05);
		chk(1'b1, 1'b1, 8'h1E, 1'b1, 15'h0000);
	endtask

	task automatic t_stack;
		ev(8'h08);
		chk(1'b1, 1'b1, 8'h1E, 1'b0, 15'h0000);
		stack_reset_enable_in = 1'b1;
		ev(8'h08);
		chk(1'b1, 1'b1, 8'h9E, 1'b1, 15'h0000);
		ev(8'h10);
		chk(1'b1, 1'b1, 8'hDE, 1'b1, 15'h0000);
	endtask

	task automatic t_sleep_wdt;
		ev(8'h40);
		chk(1'b1, 1'b1, 8'hDE, 1'b0, 15'h0000);
		ev(8'h80);
		cmp_bit("asleep", 1'b1, asleep_out);
		pc_in = 15'h1234;
		ev(8'h04);
		chk(1'b0, 1'b0, 8'hDE, 1'b1, 15'h1235);
		cmp_bit("asleep", 1'b0, asleep_out);
	endtask

	task automatic t_sleep_pin;
		ev(8'h80);
		ev(8'h02);
		chk(1'b1, 1'b0, 8'hD6, 1'b1, 15'h0000);
	endtask

	task automatic t_irq_wake;
		ev(8'h80);
		pc_in = 15'h0100;
		ev(8'h40);
		chk(1'b1, 1'b0, 8'hD6, 1'b1, 15'h0101);
		@(negedge clock_in);
		cmp_bit("stack_push", 1'b0, stack_push_out);
		global_irq_enable_in = 1'b1;
		ev(8'h80);
		pc_in = 15'h7FFE;
		ev(8'h40);
		chk(1'b1, 1'b0, 8'hD6, 1'b1, 15'h7FFF);
		@(negedge clock_in);
		chk(1'b1, 1'b0, 8'hD6, 1'b1, 15'h0004);
		cmp_bit("stack_push", 1'b1, stack_push_out);
		cmp_word("push_addr", 15'h7FFF, push_addr_out);
		// Pin reset in the vector cycle must replace the vector
		wr(8'hDF);
		ev(8'h80);
		@(negedge clock_in);
		ev_mask = 8'h40;
		@(negedge clock_in);
		ev_mask = 8'h02;
		@(negedge clock_in);
		ev_mask = 8'h00;
		chk(1'b1, 1'b0, 8'hD7, 1'b1, 15'h0000);
		cmp_bit("stack_push", 1'b0, stack_push_out);
	endtask

	// Power-on again in mid-run must restore the pattern from cleared flags
	task automatic t_second_por;
		wr(8'h00);
		@(negedge clock_in);
		rst_b_in = 1'b0;
		@(negedge clock_in);
		rst_b_in = 1'b1;
		chk(1'b1, 1'b1, 8'h1C, 1'b0, 15'h0000);
	endtask

	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end

	initial
	begin
		repeat (6) @(posedge clock_in);
		@(negedge clock_in);
		rst_b_in = 1'b1;
		t_por;
		t_write;
		t_run_resets;
		t_brownout;
		t_stack;
		t_sleep_wdt;
		t_sleep_pin;
		t_irq_wake;
		t_second_por;
		tally_and_finish;
	end
endmodule
